// ### hdl/dss_consts.svh
// Constants of the shock sequencer: timing, thresholds, register map.
// Assumes a 100 MHz clock and 12-bit measurement codes of 1 mV each.
//
// Functional notes
// - After the latch test, pulse fault_latch_clear_n low for 5 ms.
// - Conduction outputs only in shock; on-times set from patient impedance.
// - Charge and hold: blocking period 16 ms, phase two shifted 8 ms.
// - Shock: blocking period 30 ms, phases offset by 5 ms.
// - Each blocking pulse is high for 200 us.
// - Generator enable low before any charge or battery test.
// - Dump relay on for whole defibrillation cycle, off in battery test.
// - Charge command high for the charge phase, dropped when it stops.
// - Patient discharge enable low through hold until shock delivered.
// - Patient relay drive high for 100 ms during the shock.
// - Shock mode select low picks synchronised shock, tied to QRS.
// - Charge transistor fault above 1.0 V before charging: declared failed.
// - Stop charging when transformer measurement reaches target (V/850).
// - Capacitor measurement trips latch; charge never above 3.4 kV.
// - At power-up pulse fault_latch_set_n low for 5 ms.
// - Fault latch output high when set pulse or fault triggers it.
// - Relay driver conducting over 2.5 s trips the latch.
// - Bridge branch conducting over 1.5 s trips the latch.
`ifndef DSS_CONSTS_SVH
`define DSS_CONSTS_SVH

// ****************************************
// Timing
// ****************************************
`define DSS_CLK_HZ 100000000
`define DSS_US_CYC (`DSS_CLK_HZ / 1000000)
`define DSS_LATCH_PULSE_US 5000
`define DSS_CHG_PERIOD_US 16000
`define DSS_CHG_SHIFT_US 8000
`define DSS_SHK_PERIOD_US 30000
`define DSS_SHK_SHIFT_US 5000
`define DSS_BLOCK_US 200
`define DSS_RELAY_US 100000
`define DSS_RELAY_FAULT_US 2500000
`define DSS_BRIDGE_FAULT_US 1500000

// ****************************************
// Measurement thresholds
// ****************************************
`define DSS_MEAS_DIV 850
`define DSS_MV_PER_LSB 1
`define DSS_CAP_MAX_V 3400
`define DSS_CAP_MAX_CODE (`DSS_CAP_MAX_V * 1000 / `DSS_MEAS_DIV)
`define DSS_CTF_LIMIT_MV 1000
`define DSS_CTF_LIMIT_CODE (`DSS_CTF_LIMIT_MV / `DSS_MV_PER_LSB)

// ****************************************
// Register map (byte offsets) and fields
// ****************************************
`define DSS_OFS_CTRL 5'h00
`define DSS_OFS_TARGET 5'h04
`define DSS_OFS_CONDUCT 5'h08
`define DSS_OFS_STATUS 5'h0c
`define DSS_CTRL_HV_EN 0
`define DSS_CTRL_CHARGE 1
`define DSS_CTRL_SHOCK 2
`define DSS_CTRL_SYNC 3
`define DSS_CTRL_ABORT 4
`define DSS_CTRL_BATT 5
`define DSS_TARGET_RST 12'h000
`define DSS_ON_RST 16'h0000

`endif

// ### hdl/dss_pkg.sv
// Types of the shock sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package dss_pkg;

	typedef enum logic [3:0]
	{
		ST_PU_SET = 4'h0,
		ST_PU_CLR = 4'h1,
		ST_IDLE = 4'h3,
		ST_CHECK = 4'h2,
		ST_CHARGE = 4'h6,
		ST_HOLD = 4'h7,
		ST_SHOCK = 4'h5,
		ST_BATT = 4'hd,
		ST_FAULT = 4'hc
	} dss_state_t;

endpackage

// ### hdl/dss_sequencer.sv
// Shock sequencer: high-voltage stage control, blocking pulses, fault latch.
// Assumes an Avalon-MM master, synchronous inputs and 1 mV measurement codes.
`timescale 1ns/1ps
`include "dss_consts.svh"

module dss_sequencer
	import dss_pkg::*;
#(
	parameter int MEAS_W = 12,
	parameter int LATCH_US = `DSS_LATCH_PULSE_US,
	parameter int RELAY_US = `DSS_RELAY_US,
	parameter int RELAY_FAULT_US = `DSS_RELAY_FAULT_US,
	parameter int BRIDGE_FAULT_US = `DSS_BRIDGE_FAULT_US,
	parameter int CHG_PERIOD_US = `DSS_CHG_PERIOD_US,
	parameter int CHG_SHIFT_US = `DSS_CHG_SHIFT_US,
	parameter int SHK_PERIOD_US = `DSS_SHK_PERIOD_US,
	parameter int SHK_SHIFT_US = `DSS_SHK_SHIFT_US
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [MEAS_W-1:0] transformer_volt_meas,
	input wire logic [MEAS_W-1:0] capacitor_volt_meas,
	input wire logic [MEAS_W-1:0] charge_transistor_fault,
	input wire logic relay_driver_fault_sense,
	input wire logic bridge_switch_fault_sense_n,
	input wire logic discharge_key_n,
	input wire logic qrs_n,
	output logic fault_latch_set_n,
	output logic fault_latch_clear_n,
	output logic fault_latch_out,
	output logic first_phase_conduct,
	output logic first_phase_block,
	output logic second_phase_conduct,
	output logic second_phase_block,
	output logic hv_generator_enable_n,
	output logic energy_dump_relay_on,
	output logic cap_charge_cmd,
	output logic patient_discharge_enable_n,
	output logic patient_relay_drive,
	output logic shock_mode_sync_n
);

	// ****************************************
	// Microsecond timebase
	// ****************************************
	logic [7:0] div_cnt;
	logic tick;

	always_ff @(posedge clk)
	begin
		if (rst || div_cnt == 8'(`DSS_US_CYC - 1))
			div_cnt <= 8'h00;
		else
			div_cnt <= div_cnt + 8'h01;
	end

	assign tick = (div_cnt == 8'(`DSS_US_CYC - 1));

	// ****************************************
	// Avalon-MM slave
	// ****************************************
	logic wr_acc;
	logic hv_en;
	logic sync_mode;
	logic [MEAS_W-1:0] target;
	logic [15:0] ph1_on;
	logic [15:0] ph2_on;
	logic charge_go;
	logic shock_go;
	logic abort_go;
	logic batt_go;
	logic ctf_failed;
	logic latch_test_ok;
	logic safety_fault_latch;
	dss_state_t state;
	dss_state_t next_state;

	// One wait state: answer at the second edge of each request
	always_ff @(posedge clk)
	begin
		if (rst)
			avs_waitrequest <= 1'b1;
		else if ((avs_read || avs_write) && avs_waitrequest)
			avs_waitrequest <= 1'b0;
		else
			avs_waitrequest <= 1'b1;
	end

	assign wr_acc = avs_write && !avs_waitrequest;

	function automatic logic ctrl_bit(input int b);
		return wr_acc && avs_address == `DSS_OFS_CTRL && avs_writedata[b];
	endfunction

	assign charge_go = ctrl_bit(`DSS_CTRL_CHARGE);
	assign shock_go = ctrl_bit(`DSS_CTRL_SHOCK);
	assign abort_go = ctrl_bit(`DSS_CTRL_ABORT);
	assign batt_go = ctrl_bit(`DSS_CTRL_BATT);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			hv_en <= 1'b0;
			sync_mode <= 1'b0;
			target <= `DSS_TARGET_RST;
			ph1_on <= `DSS_ON_RST;
			ph2_on <= `DSS_ON_RST;
		end
		else if (wr_acc)
		begin
			case (avs_address)
				`DSS_OFS_CTRL:
				begin
					hv_en <= avs_writedata[`DSS_CTRL_HV_EN];
					sync_mode <= avs_writedata[`DSS_CTRL_SYNC];
				end
				`DSS_OFS_TARGET: target <= avs_writedata[MEAS_W-1:0];
				`DSS_OFS_CONDUCT:
				begin
					ph1_on <= avs_writedata[15:0];
					ph2_on <= avs_writedata[31:16];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && avs_waitrequest)
		begin
			case (avs_address)
				`DSS_OFS_CTRL:
					avs_readdata <= {28'h000_0000, sync_mode, 2'b00, hv_en};
				`DSS_OFS_TARGET:
					avs_readdata <= {{(32-MEAS_W){1'b0}}, target};
				`DSS_OFS_CONDUCT: avs_readdata <= {ph2_on, ph1_on};
				`DSS_OFS_STATUS:
					avs_readdata <= {24'h00_0000, !discharge_key_n,
						latch_test_ok, ctf_failed, safety_fault_latch,
						state};
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Fault detection
	// ****************************************
	logic [21:0] relay_cnt;
	logic [21:0] bridge_cnt;
	logic cap_over;
	logic trip;

	always_ff @(posedge clk)
	begin
		if (rst || !relay_driver_fault_sense)
			relay_cnt <= 22'h00_0000;
		else if (tick && relay_cnt != 22'(RELAY_FAULT_US))
			relay_cnt <= relay_cnt + 22'h00_0001;
	end

	always_ff @(posedge clk)
	begin
		if (rst || bridge_switch_fault_sense_n)
			bridge_cnt <= 22'h00_0000;
		else if (tick && bridge_cnt != 22'(BRIDGE_FAULT_US))
			bridge_cnt <= bridge_cnt + 22'h00_0001;
	end

	assign cap_over = capacitor_volt_meas > MEAS_W'(`DSS_CAP_MAX_CODE);
	assign trip = cap_over
		|| relay_cnt == 22'(RELAY_FAULT_US)
		|| bridge_cnt == 22'(BRIDGE_FAULT_US);

	// ****************************************
	// Sequence state machine
	// ****************************************
	logic [21:0] st_cnt;
	logic pulse_end;
	logic shock_req;
	logic active;
	logic [7:0] st_div;
	logic st_tick;

	// State timer runs on its own microsecond enable, restarted at every
	// state change, so that timed phases last whole microseconds exactly
	always_ff @(posedge clk)
	begin
		if (rst)
			st_div <= 8'hff; // Wraps to zero at the first edge after reset
		else if (state != next_state || st_div == 8'(`DSS_US_CYC - 1))
			st_div <= 8'h00;
		else
			st_div <= st_div + 8'h01;
	end

	assign st_tick = (st_div == 8'(`DSS_US_CYC - 1));
	assign pulse_end = st_tick && st_cnt == 22'(LATCH_US - 1);
	assign shock_req = shock_go || !discharge_key_n;
	assign active = state != ST_PU_SET && state != ST_PU_CLR
		&& state != ST_FAULT;

	always_comb
	begin
		next_state = state;
		case (state)
			ST_PU_SET: if (pulse_end) next_state = ST_PU_CLR;
			ST_PU_CLR: if (pulse_end) next_state = ST_IDLE;
			ST_IDLE:
				if (charge_go && hv_en && !ctf_failed)
					next_state = ST_CHECK;
				else if (batt_go && hv_en)
					next_state = ST_BATT;
			ST_CHECK:
				if (charge_transistor_fault >
					MEAS_W'(`DSS_CTF_LIMIT_CODE))
					next_state = ST_IDLE;
				else
					next_state = ST_CHARGE;
			ST_CHARGE:
				if (transformer_volt_meas >= target)
					next_state = ST_HOLD;
			ST_HOLD:
				if (shock_req && (!sync_mode || !qrs_n))
					next_state = ST_SHOCK;
			ST_SHOCK:
				if (st_tick && st_cnt == 22'(RELAY_US - 1))
					next_state = ST_IDLE;
			ST_BATT: ;
			ST_FAULT: ;
			default: next_state = ST_IDLE;
		endcase
		if (active && (abort_go || (!hv_en && state != ST_IDLE)))
			next_state = ST_IDLE;
		if (active && (trip || safety_fault_latch))
			next_state = ST_FAULT;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state <= ST_PU_SET;
		else
			state <= next_state;
	end

	always_ff @(posedge clk)
	begin
		if (rst || state != next_state)
			st_cnt <= 22'h00_0000;
		else if (st_tick)
			st_cnt <= st_cnt + 22'h00_0001;
	end

	// ****************************************
	// Safety latch and power-up test
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst)
			safety_fault_latch <= 1'b0;
		else if (state == ST_PU_SET || trip)
			safety_fault_latch <= 1'b1;
		else if (state == ST_PU_CLR && pulse_end)
			safety_fault_latch <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			latch_test_ok <= 1'b0;
		else if (state == ST_PU_SET && pulse_end)
			latch_test_ok <= safety_fault_latch;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			ctf_failed <= 1'b0;
		else if (state == ST_CHECK && charge_transistor_fault >
			MEAS_W'(`DSS_CTF_LIMIT_CODE))
			ctf_failed <= 1'b1;
	end

	// ****************************************
	// Blocking pulse generator
	// ****************************************
	logic [15:0] blk_cnt;
	logic blk_on;
	logic in_shock;
	logic [15:0] period;
	logic [15:0] shift;
	logic next_blk1;
	logic next_blk2;
	logic blk_clr;
	logic [7:0] blk_div;
	logic blk_tick;

	assign blk_on = state == ST_CHARGE || state == ST_HOLD
		|| state == ST_SHOCK;
	assign blk_clr = !blk_on || (state == ST_HOLD && next_state == ST_SHOCK);

	// Own enable, aligned to each pattern restart, keeps pulses whole
	always_ff @(posedge clk)
	begin
		if (rst || blk_clr || blk_div == 8'(`DSS_US_CYC - 1))
			blk_div <= 8'h00;
		else
			blk_div <= blk_div + 8'h01;
	end

	assign blk_tick = (blk_div == 8'(`DSS_US_CYC - 1));
	assign in_shock = state == ST_SHOCK;
	assign period = in_shock ? 16'(SHK_PERIOD_US) : 16'(CHG_PERIOD_US);
	assign shift = in_shock ? 16'(SHK_SHIFT_US) : 16'(CHG_SHIFT_US);

	// Restart the pattern whenever blocking starts or the shock phase begins
	always_ff @(posedge clk)
	begin
		if (rst || blk_clr)
			blk_cnt <= 16'h0000;
		else if (blk_tick)
			blk_cnt <= (blk_cnt == period - 16'h0001) ? 16'h0000 :
				blk_cnt + 16'h0001;
	end

	assign next_blk1 = blk_on && blk_cnt < 16'(`DSS_BLOCK_US);
	assign next_blk2 = blk_on && blk_cnt >= shift
		&& blk_cnt < shift + 16'(`DSS_BLOCK_US);

	// ****************************************
	// Conduction windows
	// ****************************************
	logic next_c1;
	logic next_c2;
	logic [21:0] c1_end;
	logic [21:0] c2_end;

	assign c1_end = {6'h00, ph1_on};
	assign c2_end = c1_end + {6'h00, ph2_on};
	// Phase one then phase two, each gated off by its own blocking pulse
	assign next_c1 = in_shock && st_cnt < c1_end && !next_blk1;
	assign next_c2 = in_shock && st_cnt >= c1_end && st_cnt < c2_end
		&& !next_blk2;

	// ****************************************
	// Registered outputs
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			first_phase_block <= 1'b0;
			second_phase_block <= 1'b0;
			first_phase_conduct <= 1'b0;
			second_phase_conduct <= 1'b0;
		end
		else
		begin
			first_phase_block <= next_blk1;
			second_phase_block <= next_blk2;
			first_phase_conduct <= next_c1;
			second_phase_conduct <= next_c2;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			fault_latch_set_n <= 1'b1;
			fault_latch_clear_n <= 1'b1;
			fault_latch_out <= 1'b0;
		end
		else
		begin
			fault_latch_set_n <= next_state != ST_PU_SET;
			fault_latch_clear_n <= next_state != ST_PU_CLR;
			fault_latch_out <= safety_fault_latch;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			hv_generator_enable_n <= 1'b1;
			energy_dump_relay_on <= 1'b0;
			cap_charge_cmd <= 1'b0;
			patient_discharge_enable_n <= 1'b1;
			patient_relay_drive <= 1'b0;
			shock_mode_sync_n <= 1'b1;
		end
		else
		begin
			hv_generator_enable_n <= !(hv_en && active);
			energy_dump_relay_on <= next_state == ST_CHECK
				|| next_state == ST_CHARGE || next_state == ST_HOLD
				|| next_state == ST_SHOCK;
			cap_charge_cmd <= next_state == ST_CHARGE;
			patient_discharge_enable_n <= !(next_state == ST_HOLD
				|| next_state == ST_SHOCK);
			patient_relay_drive <= next_state == ST_SHOCK;
			shock_mode_sync_n <= !(sync_mode && !qrs_n
				&& active);
		end
	end

endmodule // dss_sequencer

// ### test/dss_hv_stage.sv
// Behavioural high-voltage stage: charger, bridge and relay sense lines.
// Assumes the sequencer's 12-bit 1 mV measurement codes.
`timescale 1ns/1ps
module dss_hv_stage
(
	input wire logic clk,
	input wire logic cap_charge_cmd,
	input wire logic hv_generator_enable_n,
	input wire logic energy_dump_relay_on,
	input wire logic patient_relay_drive,
	input wire logic first_phase_conduct,
	input wire logic second_phase_conduct,
	input wire logic [11:0] ctf_level,
	input wire logic bridge_stuck,
	output logic [11:0] transformer_volt_meas,
	output logic [11:0] capacitor_volt_meas,
	output logic [11:0] charge_transistor_fault,
	output logic relay_driver_fault_sense,
	output logic bridge_switch_fault_sense_n
);
	logic [11:0] volt = 12'h000;
	// ****************************************
	// Charger: one code a cycle, emptied when the dump relay drops
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!energy_dump_relay_on)
			volt <= 12'h000;
		else if (cap_charge_cmd && !hv_generator_enable_n)
			volt <= volt + 12'h001;
	end
	assign transformer_volt_meas = volt;
	assign capacitor_volt_meas = volt;
	assign charge_transistor_fault = ctf_level;
	assign relay_driver_fault_sense = patient_relay_drive;
	assign bridge_switch_fault_sense_n =
		!(first_phase_conduct || second_phase_conduct || bridge_stuck);
endmodule // dss_hv_stage

// ### test/dss_sequencer_chk.sv
// Checker for the shock sequencer outputs.
// Assumes binding to dss_sequencer; latch and shift counts come from its parameters.
`timescale 1ns/1ps
module dss_sequencer_chk
#(
	parameter int LATCH_US = 20,
	parameter int CHG_SHIFT_US = 220,
	parameter int SHK_SHIFT_US = 220
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic fault_latch_set_n,
	input wire logic fault_latch_clear_n,
	input wire logic first_phase_conduct,
	input wire logic first_phase_block,
	input wire logic second_phase_conduct,
	input wire logic second_phase_block,
	input wire logic hv_generator_enable_n,
	input wire logic energy_dump_relay_on,
	input wire logic cap_charge_cmd,
	input wire logic patient_discharge_enable_n,
	input wire logic patient_relay_drive
);
	localparam int US = 100;
	int set_len, clr_len, b1_len, since_b1;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ****************************************
	// Pulse length counters
	// ****************************************
	always_ff @(posedge clk)
	begin
		set_len <= fault_latch_set_n ? 0 : set_len + 1;
		clr_len <= fault_latch_clear_n ? 0 : clr_len + 1;
		b1_len <= first_phase_block ? b1_len + 1 : 0;
		since_b1 <= $rose(first_phase_block) ? 0 : since_b1 + 1;
	end
	property p_set_len;
		$rose(fault_latch_set_n) |-> set_len == LATCH_US * US;
	endproperty
	a_set_len: assert property (p_set_len)
		else $error("latch set pulse length wrong");
	property p_clr_len;
		$rose(fault_latch_clear_n) |-> clr_len == LATCH_US * US;
	endproperty
	a_clr_len: assert property (p_clr_len)
		else $error("latch clear pulse length wrong");
	property p_blk_len;
		$fell(first_phase_block) |-> b1_len == 200 * US;
	endproperty
	a_blk_len: assert property (p_blk_len)
		else $error("blocking pulse length wrong");
	property p_shift;
		$rose(second_phase_block) |-> since_b1 == CHG_SHIFT_US * US - 1
			|| since_b1 == SHK_SHIFT_US * US - 1;
	endproperty
	a_shift: assert property (p_shift)
		else $error("blocking shift wrong");
	property p_no_overlap;
		!(first_phase_conduct && (first_phase_block || second_phase_conduct))
			&& !(second_phase_conduct && second_phase_block);
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("conduction overlap");
	property p_cond_shock;
		first_phase_conduct || second_phase_conduct |->
			patient_relay_drive && !patient_discharge_enable_n;
	endproperty
	a_cond_shock: assert property (p_cond_shock)
		else $error("conduction outside shock");
	property p_charge;
		cap_charge_cmd |-> energy_dump_relay_on && !hv_generator_enable_n;
	endproperty
	a_charge: assert property (p_charge)
		else $error("charging without enable or dump relay");
	property p_relay_pde;
		patient_relay_drive |-> !patient_discharge_enable_n;
	endproperty
	a_relay_pde: assert property (p_relay_pde)
		else $error("discharge enable dropped in shock");
	property p_rst_quiet;
		$past(rst) |-> !cap_charge_cmd && patient_discharge_enable_n
			&& !patient_relay_drive && !first_phase_conduct
			&& !second_phase_conduct && !energy_dump_relay_on;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("command active after reset");
	c_shock: cover property ($fell(patient_relay_drive));
	c_block2: cover property ($rose(second_phase_block));
	c_charge: cover property ($rose(cap_charge_cmd));
endmodule // dss_sequencer_chk

// ### test/tb_top.sv
// Testbench: drives the sequencer over its register bus beside a stage model.
// Assumes the shortened timing parameters set at the instance below.
`timescale 1ns/1ps
module tb_top;
	localparam int US = 100;
	localparam int RELAY_US = 300;
	localparam int LIMIT = 120000;
	localparam logic [31:0] ZERO = 32'h0000_0000;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = ZERO;
	logic [31:0] avs_readdata, q;
	logic avs_waitrequest, relay_driver_fault_sense, bridge_switch_fault_sense_n;
	logic [11:0] transformer_volt_meas, capacitor_volt_meas;
	logic [11:0] charge_transistor_fault;
	logic [11:0] ctf_level = 12'h3e8;
	logic bridge_stuck = 1'b0;
	logic discharge_key_n = 1'b1;
	logic qrs_n = 1'b1;
	logic saw_cond = 1'b0;
	logic fault_latch_set_n, fault_latch_clear_n, fault_latch_out;
	logic first_phase_conduct, first_phase_block, second_phase_conduct;
	logic second_phase_block, hv_generator_enable_n, energy_dump_relay_on;
	logic cap_charge_cmd, patient_discharge_enable_n, patient_relay_drive;
	logic shock_mode_sync_n;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;
	dss_sequencer #(.LATCH_US(20), .RELAY_US(RELAY_US), .RELAY_FAULT_US(400),
		.BRIDGE_FAULT_US(100), .CHG_PERIOD_US(440), .CHG_SHIFT_US(220),
		.SHK_PERIOD_US(450), .SHK_SHIFT_US(220)) DUT (.clk, .rst,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .transformer_volt_meas, .capacitor_volt_meas,
		.charge_transistor_fault, .relay_driver_fault_sense,
		.bridge_switch_fault_sense_n, .discharge_key_n, .qrs_n,
		.fault_latch_set_n, .fault_latch_clear_n, .fault_latch_out,
		.first_phase_conduct, .first_phase_block, .second_phase_conduct,
		.second_phase_block, .hv_generator_enable_n, .energy_dump_relay_on,
		.cap_charge_cmd, .patient_discharge_enable_n, .patient_relay_drive,
		.shock_mode_sync_n);
	dss_hv_stage u_stage (.clk, .cap_charge_cmd, .hv_generator_enable_n,
		.energy_dump_relay_on, .patient_relay_drive, .first_phase_conduct,
		.second_phase_conduct, .ctf_level, .bridge_stuck,
		.transformer_volt_meas, .capacitor_volt_meas, .charge_transistor_fault,
		.relay_driver_fault_sense, .bridge_switch_fault_sense_n);
	always #5 clk = ~clk;
	// ****************************************
	// Cycle limit and conduction monitor
	// ****************************************
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (first_phase_conduct || second_phase_conduct)
			saw_cond <= 1'b1;
		if (cyc == LIMIT)
		begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Avalon transfer: held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_state(input logic [3:0] s);
		do
			bus(1'b0, 5'h0c, ZERO);
		while (q[3:0] !== s);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		int n;
		step(16);
		rst <= 1'b0;
		step(3);
		chk("set pulse", 1'b0, fault_latch_set_n);
		wait_state(4'h3);
		chk("latch test", 32'h0000_0040, q & 32'h0000_0050);
		bus(1'b1, 5'h04, 32'h0000_0100);
		bus(1'b1, 5'h08, 32'h005a_00d2);
		bus(1'b1, 5'h0c, 32'hffff_ffff);
		bus(1'b0, 5'h04, ZERO);
		chk("target", 32'h0000_0100, q);
		bus(1'b0, 5'h08, ZERO);
		chk("conduct times", 32'h005a_00d2, q);
		bus(1'b0, 5'h10, ZERO);
		chk("unmapped", ZERO, q);
		bus(1'b0, 5'h0c, ZERO);
		chk("status ro", 4'h3, q[3:0]);
		bus(1'b1, 5'h00, 32'h0000_0001);
		step(2);
		chk("hv enable", 1'b0, hv_generator_enable_n);
		bus(1'b1, 5'h00, 32'h0000_0003);
		wait_state(4'h6);
		chk("charging", 2'b11, {cap_charge_cmd, energy_dump_relay_on});
		wait_state(4'h7);
		chk("hold", 2'b00, {cap_charge_cmd, patient_discharge_enable_n});
		while (second_phase_block !== 1'b1)
			@(posedge clk);
		chk("block pair", 1'b0, first_phase_block);
		bus(1'b1, 5'h00, 32'h0000_0009);
		qrs_n <= 1'b0;
		step(3);
		chk("sync", 1'b0, shock_mode_sync_n);
		discharge_key_n <= 1'b0;
		while (patient_relay_drive !== 1'b1)
			@(posedge clk);
		n = 0;
		while (patient_relay_drive === 1'b1)
		begin
			n++;
			@(posedge clk);
		end
		chk("relay time", RELAY_US * US, n);
		chk("conduction", 1'b1, saw_cond);
		discharge_key_n <= 1'b1;
		qrs_n <= 1'b1;
		wait_state(4'h3);
		chk("discharge off", 1'b1, patient_discharge_enable_n);
		bus(1'b1, 5'h00, 32'h0000_0021);
		wait_state(4'hd);
		chk("battery", 2'b00, {energy_dump_relay_on, hv_generator_enable_n});
		bus(1'b1, 5'h00, 32'h0000_0011);
		wait_state(4'h3);
		ctf_level <= 12'h3e9;
		bus(1'b1, 5'h00, 32'h0000_0003);
		step(3);
		bus(1'b0, 5'h0c, ZERO);
		chk("ctf failed", 32'h0000_0023, q & 32'h0000_002f);
		chk("no charge", 1'b0, cap_charge_cmd);
		bridge_stuck <= 1'b1;
		wait_state(4'hc);
		chk("latch out", 1'b1, fault_latch_out);
		end_sim();
	end
endmodule // tb_top

bind dss_sequencer dss_sequencer_chk #(.LATCH_US(LATCH_US),
	.CHG_SHIFT_US(CHG_SHIFT_US), .SHK_SHIFT_US(SHK_SHIFT_US)) u_chk (.clk,
	.rst, .fault_latch_set_n, .fault_latch_clear_n, .first_phase_conduct,
	.first_phase_block, .second_phase_conduct, .second_phase_block,
	.hv_generator_enable_n, .energy_dump_relay_on, .cap_charge_cmd,
	.patient_discharge_enable_n, .patient_relay_drive);
